// ==== rtl/spc_pointer_unit.v ====
// Serial slave command unit: pointer commands, streamed reads and writes
// Function
// - Commands D0, D2, D4 add 1, 2 or 4 to active pointer, no data.
// - Active pointer chosen by select field bits 11-10 of configuration word.
// - Fast-access commands never alter the active pointer.
// - Command 40 reads at pointer, then streams with auto-increment.
// - Command C0 writes at pointer, further words auto-increment.
// - Command C8 adds one to pointer, then writes there.
// - Each read fetches word, advances pointer, prefetches next word.
// - No prefetch or advance when next address is a control word.
// - Control words are table base plus multiples of four up to 1FC.
// - Completed bus command sets block_accessed_flag in its control word.
// - Any read of a control word, fetch or indirect, clears its flag.
// - Command 48 loads control word address into pointer, reads, increments.
// - Commands 68, 70, 78 add 0-2, read, load pointer, stream reads.
// - Commands E8, F0, F8 add 0-2, load pointer from memory, then write.
// - Command byte MSB zero reads, one writes.
// - Words travel high byte first.
// - Pointer wraps from 1FFF to 0000.
// - Chip enable rising ends transfer, partial byte discarded.
`include "spc_map.vh"

module spc_pointer_unit (
	input wire clk,
	input wire rst_n,
	input wire clkEn,
	input wire sck,
	input wire ceN,
	input wire si,
	output reg so,
	output reg soEn,
	input wire [15:0] masterConfig,
	input wire [15:0] descBase,
	input wire [15:0] curCtlWordAddr,
	input wire busCmdDone,
	output reg [12:0] memAddr,
	output reg memRdEn,
	output reg memWrEn,
	output reg [15:0] memWrData,
	output reg memFlagSet,
	output reg memFlagClr,
	input wire [15:0] memRdData,
	input wire memWrGrant,
	output reg [12:0] activePointer,
	output reg writeOverflow
);

	// ***********************************************
	// Encodings
	// ***********************************************
	localparam PH_CMD = 2'b00;
	localparam PH_READ = 2'b01;
	localparam PH_WRITE = 2'b10;
	localparam PH_IGNORE = 2'b11;
	localparam SQ_IDLE = 2'b00;
	localparam SQ_ISSUE = 2'b01;
	localparam SQ_WAIT = 2'b10;
	localparam SQ_CAPT = 2'b11;
	localparam OP_FETCH = 2'b00;
	localparam OP_PREF = 2'b01;
	localparam OP_INDR = 2'b10;
	localparam OP_INDW = 2'b11;

	// ***********************************************
	// Helpers
	// ***********************************************
	function isCtl;
		input [12:0] addr;
		input [15:0] base;
		reg [13:0] diff;
		begin
			diff = {1'b0, addr} - {1'b0, base[`SPC_ADDR_HI:0]};
			isCtl = !diff[`SPC_ADDR_W] && (diff[`SPC_ADDR_HI:0] <= `SPC_CTL_SPAN) &&
				((diff[`SPC_ADDR_HI:0] & `SPC_CTL_STRIDE_MASK) == `SPC_STEP0);
		end
	endfunction

	// ***********************************************
	// Reset release and pin synchronisers
	// ***********************************************
	reg rstMeta_reg;
	reg rstSync_reg;
	wire rstInt_n;
	reg sckMeta_reg;
	reg sckSync_reg;
	reg sckPrev_reg;
	reg ceMeta_reg;
	reg ceSync_reg;
	reg siMeta_reg;
	reg siSync_reg;

	assign rstInt_n = rstSync_reg;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta_reg <= 1'b0;
			rstSync_reg <= 1'b0;
		end else if (clkEn) begin
			rstMeta_reg <= 1'b1;
			rstSync_reg <= rstMeta_reg;
		end
	end

	// Idle levels: clock low, chip enable high
	always @(posedge clk or negedge rstInt_n) begin
		if (!rstInt_n) begin
			sckMeta_reg <= 1'b0;
			sckSync_reg <= 1'b0;
			sckPrev_reg <= 1'b0;
			ceMeta_reg <= 1'b1;
			ceSync_reg <= 1'b1;
			siMeta_reg <= 1'b0;
			siSync_reg <= 1'b0;
		end else if (clkEn) begin
			sckMeta_reg <= sck;
			sckSync_reg <= sckMeta_reg;
			sckPrev_reg <= sckSync_reg;
			ceMeta_reg <= ceN;
			ceSync_reg <= ceMeta_reg;
			siMeta_reg <= si;
			siSync_reg <= siMeta_reg;
		end
	end

	// Mode 0 and mode 3 both sample on rising edges, so one detector serves
	wire sckRise = sckSync_reg & ~sckPrev_reg;
	wire sckFall = ~sckSync_reg & sckPrev_reg;
	wire selected = ~ceSync_reg;

	// ***********************************************
	// State
	// ***********************************************
	reg [1:0] phase_reg;
	reg [1:0] seq_reg;
	reg [1:0] op_reg;
	reg [2:0] bitCnt_reg;
	reg [3:0] rxCnt_reg;
	reg [15:0] rxShift_reg;
	reg [15:0] txWord_reg;
	reg [15:0] nextWord_reg;
	reg nextValid_reg;
	reg flagPend_reg;
	reg pushReg_reg;
	reg [28:0] pushData_reg;
	reg [12:0] ptrs [0:3];
	integer i;

	wire [1:0] selIdx = masterConfig[`SPC_SEL_HI:`SPC_SEL_LO];
	wire [12:0] curPtr = ptrs[selIdx];
	wire [12:0] curPtrInc = curPtr + `SPC_STEP1;
	wire [7:0] cmdByte = {rxShift_reg[6:0], siSync_reg};
	wire [15:0] rxWord = {rxShift_reg[14:0], siSync_reg};
	wire fifoInReady;
	wire fifoOutValid;
	wire [28:0] fifoOutData;
	// Reads wait for queued writes so a read never sees stale memory
	wire seqGo = (seq_reg == SQ_ISSUE) & ~fifoOutValid & ~pushReg_reg & selected;
	wire fifoOutReady = ~seqGo & ~flagPend_reg & memWrGrant;

	// ***********************************************
	// Write queue
	// ***********************************************
	spc_fifo #(
		.WIDTH(`SPC_FIFO_W),
		.DEPTH(`SPC_FIFO_D),
		.AW(`SPC_FIFO_AW)
	) writeQueue (
		.clk(clk),
		.rstInt_n(rstInt_n),
		.clkEn(clkEn),
		.inValid(pushReg_reg),
		.inReady(fifoInReady),
		.inData(pushData_reg),
		.outValid(fifoOutValid),
		.outReady(fifoOutReady),
		.outData(fifoOutData)
	);

	// ***********************************************
	// Command, memory sequencing and serial shifting
	// ***********************************************
	always @(posedge clk or negedge rstInt_n) begin
		if (!rstInt_n) begin
			so <= 1'b0;
			soEn <= 1'b0;
			memAddr <= `SPC_PTR_RESET;
			memRdEn <= 1'b0;
			memWrEn <= 1'b0;
			memWrData <= `SPC_WORD_RESET;
			memFlagSet <= 1'b0;
			memFlagClr <= 1'b0;
			activePointer <= `SPC_PTR_RESET;
			writeOverflow <= 1'b0;
			phase_reg <= PH_CMD;
			seq_reg <= SQ_IDLE;
			op_reg <= OP_FETCH;
			bitCnt_reg <= 3'h0;
			rxCnt_reg <= 4'h0;
			rxShift_reg <= `SPC_WORD_RESET;
			txWord_reg <= `SPC_WORD_RESET;
			nextWord_reg <= `SPC_WORD_RESET;
			nextValid_reg <= 1'b0;
			flagPend_reg <= 1'b0;
			pushReg_reg <= 1'b0;
			pushData_reg <= {`SPC_FIFO_W{1'b0}};
			for (i = 0; i < 4; i = i + 1) begin
				ptrs[i] <= `SPC_PTR_RESET;
			end
		end else if (clkEn) begin
			memRdEn <= 1'b0;
			memWrEn <= 1'b0;
			memFlagSet <= 1'b0;
			memFlagClr <= 1'b0;
			pushReg_reg <= 1'b0;
			activePointer <= curPtr;
			// A dropped word is sticky; the host cannot be stalled
			if (pushReg_reg && !fifoInReady) begin
				writeOverflow <= 1'b1;
			end

			// Single memory port: sequencer read, flag update, queued write
			if (seqGo) begin
				memRdEn <= 1'b1;
				memAddr <= curPtr;
				memFlagClr <= isCtl(curPtr, descBase);
				seq_reg <= SQ_WAIT;
			end else if (flagPend_reg) begin
				memFlagSet <= 1'b1;
				memAddr <= curCtlWordAddr[`SPC_ADDR_HI:0];
				flagPend_reg <= 1'b0;
			end else if (fifoOutValid && memWrGrant) begin
				memWrEn <= 1'b1;
				memAddr <= fifoOutData[`SPC_FIFO_W-1:`SPC_WORD_W];
				memWrData <= fifoOutData[`SPC_WORD_W-1:0];
			end

			case (seq_reg)
				SQ_WAIT: begin
					seq_reg <= SQ_CAPT;
				end
				SQ_CAPT: begin
					seq_reg <= SQ_IDLE;
					case (op_reg)
						OP_FETCH: begin
							txWord_reg <= memRdData;
							so <= memRdData[`SPC_MSB];
							if (!isCtl(curPtrInc, descBase)) begin
								ptrs[selIdx] <= curPtrInc;
								op_reg <= OP_PREF;
								seq_reg <= SQ_ISSUE;
							end
						end
						OP_PREF: begin
							nextWord_reg <= memRdData;
							nextValid_reg <= 1'b1;
						end
						OP_INDR: begin
							ptrs[selIdx] <= memRdData[`SPC_ADDR_HI:0];
							op_reg <= OP_FETCH;
							seq_reg <= SQ_ISSUE;
						end
						default: begin
							ptrs[selIdx] <= memRdData[`SPC_ADDR_HI:0];
						end
					endcase
				end
				default: begin
				end
			endcase

			if (!selected) begin
				phase_reg <= PH_CMD;
				bitCnt_reg <= 3'h0;
				rxCnt_reg <= 4'h0;
				seq_reg <= SQ_IDLE;
				nextValid_reg <= 1'b0;
				soEn <= 1'b0;
			end else begin
				if (sckRise) begin
					rxShift_reg <= rxWord;
					case (phase_reg)
						PH_CMD: begin
							bitCnt_reg <= bitCnt_reg + 3'h1;
							if (bitCnt_reg == `SPC_BIT_LAST) begin
								// Direction from MSB; unknown codes fall to ignore
								phase_reg <= cmdByte[`SPC_CMD_DIR_BIT] ? PH_WRITE : PH_READ;
								soEn <= ~cmdByte[`SPC_CMD_DIR_BIT];
								op_reg <= OP_FETCH;
								case (cmdByte)
									`SPC_CMD_INC1: begin
										ptrs[selIdx] <= curPtrInc;
										phase_reg <= PH_IGNORE;
									end
									`SPC_CMD_INC2: begin
										ptrs[selIdx] <= curPtr + `SPC_STEP2;
										phase_reg <= PH_IGNORE;
									end
									`SPC_CMD_INC4: begin
										ptrs[selIdx] <= curPtr + `SPC_STEP4;
										phase_reg <= PH_IGNORE;
									end
									`SPC_CMD_RD: begin
										seq_reg <= SQ_ISSUE;
									end
									`SPC_CMD_RD_CCW: begin
										ptrs[selIdx] <= curCtlWordAddr[`SPC_ADDR_HI:0];
										seq_reg <= SQ_ISSUE;
									end
									`SPC_CMD_RD_IND0, `SPC_CMD_RD_IND1, `SPC_CMD_RD_IND2: begin
										if (cmdByte == `SPC_CMD_RD_IND1) begin
											ptrs[selIdx] <= curPtrInc;
										end else if (cmdByte == `SPC_CMD_RD_IND2) begin
											ptrs[selIdx] <= curPtr + `SPC_STEP2;
										end
										op_reg <= OP_INDR;
										seq_reg <= SQ_ISSUE;
									end
									`SPC_CMD_WR: begin
									end
									`SPC_CMD_WR_INC: begin
										ptrs[selIdx] <= curPtrInc;
									end
									`SPC_CMD_WR_IND0, `SPC_CMD_WR_IND1, `SPC_CMD_WR_IND2: begin
										if (cmdByte == `SPC_CMD_WR_IND1) begin
											ptrs[selIdx] <= curPtrInc;
										end else if (cmdByte == `SPC_CMD_WR_IND2) begin
											ptrs[selIdx] <= curPtr + `SPC_STEP2;
										end
										op_reg <= OP_INDW;
										seq_reg <= SQ_ISSUE;
									end
									default: begin
										// Fast-access and other codes leave pointers alone
										phase_reg <= PH_IGNORE;
										soEn <= 1'b0;
									end
								endcase
							end
						end
						PH_READ: begin
							rxCnt_reg <= rxCnt_reg + 4'h1;
							// Advance only when the host starts the next word, so an
							// unread prefetch leaves the pointer on that word
							if (rxCnt_reg == 4'h0 && !nextValid_reg && seq_reg == SQ_IDLE &&
								!isCtl(curPtrInc, descBase)) begin
								ptrs[selIdx] <= curPtrInc;
								op_reg <= OP_PREF;
								seq_reg <= SQ_ISSUE;
							end
							if (rxCnt_reg == `SPC_WBIT_LAST) begin
								if (nextValid_reg) begin
									txWord_reg <= nextWord_reg;
									so <= nextWord_reg[`SPC_MSB];
									nextValid_reg <= 1'b0;
								end else begin
									// Blocked at a control word: the same word repeats
									so <= txWord_reg[`SPC_MSB];
								end
							end
						end
						PH_WRITE: begin
							rxCnt_reg <= rxCnt_reg + 4'h1;
							if (rxCnt_reg == `SPC_WBIT_LAST) begin
								pushReg_reg <= 1'b1;
								pushData_reg <= {curPtr, rxWord};
								ptrs[selIdx] <= curPtrInc;
							end
						end
						default: begin
						end
					endcase
				end
				if (sckFall && phase_reg == PH_READ && rxCnt_reg != 4'h0) begin
					so <= txWord_reg[`SPC_WBIT_TOP - rxCnt_reg];
				end
			end
			// Set wins over the clear issued above in the same cycle
			if (busCmdDone) begin
				flagPend_reg <= 1'b1;
			end
		end
	end

endmodule

// ==== rtl/spc_map.vh ====
// Constants for the serial pointer command unit
`ifndef SPC_MAP_VH
`define SPC_MAP_VH

// ***********************************************
// Command bytes
// ***********************************************
`define SPC_CMD_INC1 8'hD0
`define SPC_CMD_INC2 8'hD2
`define SPC_CMD_INC4 8'hD4
`define SPC_CMD_RD 8'h40
`define SPC_CMD_RD_CCW 8'h48
`define SPC_CMD_RD_IND0 8'h68
`define SPC_CMD_RD_IND1 8'h70
`define SPC_CMD_RD_IND2 8'h78
`define SPC_CMD_WR 8'hC0
`define SPC_CMD_WR_INC 8'hC8
`define SPC_CMD_WR_IND0 8'hE8
`define SPC_CMD_WR_IND1 8'hF0
`define SPC_CMD_WR_IND2 8'hF8
`define SPC_CMD_DIR_BIT 7

// ***********************************************
// Configuration fields and address layout
// ***********************************************
`define SPC_SEL_HI 11
`define SPC_SEL_LO 10
`define SPC_ADDR_HI 12
`define SPC_ADDR_W 13
`define SPC_WORD_W 16
`define SPC_FIFO_W 29
`define SPC_FIFO_D 16
`define SPC_FIFO_AW 4
`define SPC_STEP0 13'h0000
`define SPC_STEP1 13'h0001
`define SPC_STEP2 13'h0002
`define SPC_STEP4 13'h0004
`define SPC_CTL_SPAN 13'h01FC
`define SPC_CTL_STRIDE_MASK 13'h0003
`define SPC_PTR_RESET 13'h0000
`define SPC_WORD_RESET 16'h0000
`define SPC_BIT_LAST 3'h7
`define SPC_WBIT_LAST 4'hF
`define SPC_WBIT_TOP 4'hF
`define SPC_MSB 15

`endif

// ==== rtl/spc_fifo.v ====
// Parameterised first-word-fall-through FIFO with valid/ready on both sides
module spc_fifo #(
	parameter WIDTH = 29,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire clk,
	input wire rstInt_n,
	input wire clkEn,
	input wire inValid,
	output wire inReady,
	input wire [WIDTH-1:0] inData,
	output wire outValid,
	input wire outReady,
	output wire [WIDTH-1:0] outData
);

	// ***********************************************
	// Storage and pointers
	// ***********************************************
	reg [WIDTH-1:0] store [0:DEPTH-1];
	reg [AW-1:0] wrPtr_reg;
	reg [AW-1:0] rdPtr_reg;
	reg [AW:0] count_reg;
	wire doPush;
	wire doPop;

	// Honest flags: full and empty come straight from the count
	assign inReady = (count_reg != DEPTH[AW:0]);
	assign outValid = (count_reg != {(AW+1){1'b0}});
	assign outData = store[rdPtr_reg];
	assign doPush = inValid & inReady;
	assign doPop = outValid & outReady;

	always @(posedge clk) begin
		if (clkEn && doPush) begin
			store[wrPtr_reg] <= inData;
		end
	end

	always @(posedge clk or negedge rstInt_n) begin
		if (!rstInt_n) begin
			wrPtr_reg <= {AW{1'b0}};
			rdPtr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
		end else if (clkEn) begin
			if (doPush) begin
				wrPtr_reg <= wrPtr_reg + {{(AW-1){1'b0}}, 1'b1};
			end
			if (doPop) begin
				rdPtr_reg <= rdPtr_reg + {{(AW-1){1'b0}}, 1'b1};
			end
			if (doPush && !doPop) begin
				count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
			end else if (doPop && !doPush) begin
				count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
			end
		end
	end

endmodule

// ==== verif/spc_monitor.sv ====
// Checker of the pointer command unit ports
// ***********
// Assertions
// ***********
module spc_monitor (
	input wire clk,
	input wire rst_n,
	input wire ceN,
	input wire soEn,
	input wire [15:0] descBase,
	input wire [15:0] curCtlWordAddr,
	input wire busCmdDone,
	input wire [12:0] memAddr,
	input wire memRdEn,
	input wire memWrEn,
	input wire memFlagSet,
	input wire memFlagClr
);
	timeunit 1ns;
	timeprecision 1ns;
	wire [12:0] ctlOff = memAddr - descBase[12:0];
	wire isCtl = (memAddr >= descBase[12:0]) && (ctlOff <= 13'h01FC) && (ctlOff[1:0] == 2'h0);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	AST_ONE_OP: assert property ($onehot0({memRdEn, memWrEn, memFlagSet}))
		else $error("two memory operations at once");
	AST_CLR_RD: assert property (memFlagClr |-> memRdEn)
		else $error("flag clear without read");
	AST_CTL_CLR: assert property (memRdEn |-> (memFlagClr == isCtl))
		else $error("flag clear does not match control word");
	AST_SET_ADDR: assert property (memFlagSet |-> memAddr == curCtlWordAddr[12:0])
		else $error("flag set at wrong address");
	AST_SET_DONE: assert property (busCmdDone |-> ##[1:20] memFlagSet)
		else $error("flag set missing");
	AST_DESEL_OFF: assert property (ceN [*5] |-> !soEn)
		else $error("output enabled while deselected");
	AST_DESEL_NORD: assert property (ceN [*8] |-> !memRdEn)
		else $error("read while deselected");
	AST_SOEN_SEL: assert property ($rose(soEn) |-> !ceN && !$past(ceN, 2))
		else $error("output enable without selection");
	AST_RD_START: assert property ($rose(soEn) |-> ##[1:20] memRdEn)
		else $error("no fetch after read command");
endmodule

bind spc_pointer_unit spc_monitor mon (.clk(clk), .rst_n(rst_n), .ceN(ceN), .soEn(soEn),
	.descBase(descBase), .curCtlWordAddr(curCtlWordAddr), .busCmdDone(busCmdDone),
	.memAddr(memAddr), .memRdEn(memRdEn), .memWrEn(memWrEn), .memFlagSet(memFlagSet),
	.memFlagClr(memFlagClr));

// ==== verif/spc_host_model.sv ====
// Serial master model on the host side of the link
// ***********
// Host master
// ***********
module spc_host_model (
	output logic sck,
	output logic ceN,
	output logic si,
	input wire so
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] rdQ[$];
	initial begin
		sck = 1'b0;
		ceN = 1'b1;
		si = 1'b0;
	end
	task automatic shift(input logic [15:0] d, input int n, output logic [15:0] q);
		q = 16'h0000;
		for (int i = n - 1; i >= 0; i--) begin
			si <= d[i];
			#200 sck <= 1'b1;
			q[i] = so;
			#200 sck <= 1'b0;
		end
	endtask
	// Odd lead-in keeps the frame unrelated in phase to the system clock
	task automatic frame(input logic [7:0] cmd, input int nw, input logic [15:0] wd, input int part);
		logic [15:0] q;
		#37 ceN <= 1'b0;
		#300 shift({8'h00, cmd}, 8, q);
		#200 rdQ.delete();
		for (int w = 0; w < nw; w++) begin
			shift(wd + w[15:0], 16, q);
			rdQ.push_back(q);
		end
		if (part > 0) shift(wd, part, q);
		#300 ceN <= 1'b1;
		si <= ~si;
		#1000;
	endtask
endmodule

// ==== verif/testbench.sv ====
// Self-checking bench of the pointer command unit
`include "spc_map.vh"
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_n, clkEn, busCmdDone, memWrGrant;
	logic [15:0] masterConfig, descBase, curCtlWordAddr, memRdData;
	wire sck, ceN, si, so, soEn, memRdEn, memWrEn, memFlagSet, memFlagClr, writeOverflow;
	wire [12:0] memAddr, activePointer;
	wire [15:0] memWrData;
	logic [15:0] mem [0:8191];
	int fail_count = 0;
	int tests_run = 0;
	int accCnt = 0;
	spc_pointer_unit uut (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .sck(sck), .ceN(ceN),
		.si(si), .so(so), .soEn(soEn), .masterConfig(masterConfig), .descBase(descBase),
		.curCtlWordAddr(curCtlWordAddr), .busCmdDone(busCmdDone), .memAddr(memAddr),
		.memRdEn(memRdEn), .memWrEn(memWrEn), .memWrData(memWrData), .memFlagSet(memFlagSet),
		.memFlagClr(memFlagClr), .memRdData(memRdData), .memWrGrant(memWrGrant),
		.activePointer(activePointer), .writeOverflow(writeOverflow));
	spc_host_model host (.sck(sck), .ceN(ceN), .si(si), .so(so));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// ***********
	// Memory model
	// ***********
	// Read data scrambles outside its valid cycle so a late capture shows
	always @(posedge clk) begin
		if (memRdEn) memRdData <= mem[memAddr];
		else memRdData <= ~memRdData;
		if (memFlagClr) mem[memAddr][15] <= 1'b0;
		if (memFlagSet) mem[memAddr][15] <= 1'b1;
		if (memWrEn) mem[memAddr] <= memWrData;
		if (memRdEn | memWrEn) accCnt++;
	end
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task chkPtr(input logic [12:0] e);
		chk({3'h0, activePointer}, {3'h0, e});
	endtask
	task waitClk(input int n);
		repeat (n) @(posedge clk);
	endtask
	task print_verdict;
		$display("Checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task t_adjust;
		accCnt = 0;
		host.frame(`SPC_CMD_INC4, 1, 16'hFFFF, 0);
		chkPtr(13'h0004);
		host.frame(`SPC_CMD_INC2, 0, 16'h0000, 0);
		chkPtr(13'h0006);
		host.frame(`SPC_CMD_INC1, 0, 16'h0000, 0);
		chkPtr(13'h0007);
		chk(accCnt[15:0], 16'h0000);
		@(posedge clk) masterConfig <= 16'h0400;
		waitClk(3);
		chkPtr(13'h0000);
		@(posedge clk) masterConfig <= 16'h0000;
		waitClk(3);
		chkPtr(13'h0007);
		$display("Test adjust done");
	endtask
	task t_rw;
		host.frame(`SPC_CMD_RD, 3, 16'h0000, 0);
		for (int i = 0; i < 3; i++) chk(host.rdQ[i], 16'h6007 + i[15:0]);
		chkPtr(13'h000A);
		@(posedge clk) memWrGrant <= 1'b0;
		host.frame(`SPC_CMD_WR, 2, 16'hBEE0, 8);
		chk(mem[10], 16'h600A);
		@(posedge clk) memWrGrant <= 1'b1;
		waitClk(20);
		chk(mem[11], 16'hBEE1);
		chk(mem[12], 16'h600C);
		host.frame(`SPC_CMD_WR_INC, 1, 16'h1234, 0);
		chk(mem[13], 16'h1234);
		chk(mem[12], 16'h600C);
		chkPtr(13'h000E);
		$display("Test read write done");
	endtask
	task t_ctl;
		@(posedge clk) begin
			curCtlWordAddr <= 16'h0408;
			busCmdDone <= 1'b1;
		end
		@(posedge clk) busCmdDone <= 1'b0;
		waitClk(10);
		chk(mem[13'h408], 16'hE408);
		host.frame(`SPC_CMD_RD_CCW, 1, 16'h0000, 0);
		chk(host.rdQ[0], 16'hE408);
		chk(mem[13'h408], 16'h6408);
		chkPtr(13'h0409);
		mem[13'h40C] = 16'hE40C;
		host.frame(`SPC_CMD_RD, 5, 16'h0000, 0);
		for (int i = 0; i < 5; i++) chk(host.rdQ[i], 16'h6409 + (i < 2 ? i[15:0] : 16'h0002));
		chk(mem[13'h40C], 16'hE40C);
		chkPtr(13'h040B);
		$display("Test control words done");
	endtask
	task t_indirect;
		logic [7:0] cmds [6];
		logic [12:0] p, tgt;
		cmds = '{8'h68, 8'h70, 8'h78, 8'hE8, 8'hF0, 8'hF8};
		p = 13'h040B;
		for (int k = 0; k < 6; k++) begin
			tgt = 13'h0300 + {k[8:0], 4'h0};
			mem[p + (k % 3)] = {3'h3, tgt};
			host.frame(cmds[k], 1, 16'hC000 + k[15:0], 0);
			if (k < 3) chk(host.rdQ[0], {3'h3, tgt});
			else chk(mem[tgt], 16'hC000 + k[15:0]);
			p = tgt + 13'h0001;
			chkPtr(p);
		end
		mem[p] = 16'h1FFE;
		host.frame(`SPC_CMD_RD_IND0, 3, 16'h0000, 0);
		chk(host.rdQ[2], 16'h6000);
		chkPtr(13'h0001);
		$display("Test indirect done");
	endtask
	task t_fifo;
		chk({15'h0000, writeOverflow}, 16'h0000);
		@(posedge clk) memWrGrant <= 1'b0;
		host.frame(`SPC_CMD_WR, 17, 16'h7100, 0);
		chk({15'h0000, writeOverflow}, 16'h0001);
		@(posedge clk) memWrGrant <= 1'b1;
		waitClk(40);
		chk(mem[1], 16'h7100);
		chk(mem[16], 16'h710F);
		chk(mem[17], 16'h6011);
		$display("Test buffer done");
	endtask
	initial begin
		rst_n = 1'b0;
		clkEn = 1'b1;
		busCmdDone = 1'b0;
		memWrGrant = 1'b1;
		masterConfig = 16'h0000;
		descBase = 16'h0400;
		curCtlWordAddr = 16'h0000;
		memRdData = 16'h0000;
		for (int i = 0; i < 8192; i++) mem[i] = {3'h3, i[12:0]};
		waitClk(2);
		rst_n <= 1'b1;
		waitClk(5);
		t_adjust;
		t_rw;
		t_ctl;
		t_indirect;
		t_fifo;
		print_verdict;
	end
	// Hang guard: a stuck frame must still reach the verdict
	initial begin
		#4ms;
		fail_count++;
		print_verdict;
	end
endmodule
